// ---- core/pcpl_pot_control.sv ----
`timescale 1ns/1ps
module pcpl_pot_control
	import pcpl_pkg::*;
#(
	parameter int STORE_CYCLES = PCPL_STORE_CYC,
	parameter int READY_CYCLES = PCPL_READY_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        linkClk,
	input  wire logic        chipSel_b,
	input  wire logic        serialIn,
	input  wire logic        writeProtect_b,
	input  wire logic        preset_strobe_n,
	output logic             readyOut,
	output logic             readyOe_b,
	output logic             nv_digital_out_one,
	output logic             nv_digital_out_two,
	output logic [23:0]      wiperFlat,
	output logic             storeBusy
);
	initial begin
		if (STORE_CYCLES < 1 || STORE_CYCLES > 2**30) $error("pcpl_pot_control: bad STORE_CYCLES");
		if (READY_CYCLES < 1) $error("pcpl_pot_control: bad READY_CYCLES");
	end

	typedef enum logic [1:0] {PCPL_IDLE, PCPL_STORING, PCPL_READY} pcpl_state_t;

	logic [15:0] linkWord;
	logic        linkToggle;
	logic [15:0] wordSync;
	logic [2:0]  ctrlSync;
	logic        toggleSync;
	logic        writeProt_b;
	logic        presetSync;

	pcpl_shift #(.WORD_BITS(PCPL_WORD_BITS)) u_shift (
		.linkClk    (linkClk),
		.rst_b      (rst_b),
		.chipSel_b  (chipSel_b),
		.serialIn   (serialIn),
		.wordOut    (linkWord),
		.wordToggle (linkToggle)
	);

	// Word taken a cycle after its toggle shows, once every bit has settled
	pcpl_sync #(.WIDTH(16)) u_word_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.asyncIn (linkWord),
		.syncOut (wordSync)
	);

	// Toggle carried inverted so the all-ones reset matches an idle link
	pcpl_sync #(.WIDTH(3)) u_ctrl_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.asyncIn ({~linkToggle, writeProtect_b, preset_strobe_n}),
		.syncOut (ctrlSync)
	);

	assign toggleSync  = ~ctrlSync[2];
	assign writeProt_b = ctrlSync[1];
	assign presetSync  = ctrlSync[0];

	logic        toggle_reg;
	logic        preset_reg;
	logic [15:0] word_reg;
	logic        wordValid_reg;
	logic [5:0]  wiper_reg   [PCPL_CHANNELS];
	logic [5:0]  nvStore_reg [PCPL_CHANNELS];
	logic        nvOne_reg;
	logic        nvTwo_reg;
	pcpl_state_t state_reg;
	logic [31:0] count_reg;
	logic [1:0]  storeCh_reg;
	logic        storeWiper_reg;
	logic        wordPend_reg;

	wire         newWord     = toggleSync != toggle_reg;
	wire         presetRise  = presetSync && !preset_reg;
	wire         presetLow   = !presetSync;
	wire [3:0]   cmdField    = word_reg[PCPL_CMD_MSB:PCPL_CMD_LSB];
	wire [3:0]   addrField   = word_reg[PCPL_ADDR_MSB:PCPL_ADDR_LSB];
	wire [5:0]   dataField   = word_reg[PCPL_WIPER_BITS-1:0];
	wire         idle        = state_reg == PCPL_IDLE;
	wire         execute     = wordValid_reg && idle;
	wire         isRestore   = cmdField == PCPL_CMD_RESTORE || cmdField == PCPL_CMD_RESET_NV;
	wire         isStore     = cmdField == PCPL_CMD_STORE || cmdField == PCPL_CMD_STORE_U;
	wire         isRead      = cmdField == PCPL_CMD_READ_NV || cmdField == PCPL_CMD_READ_W;
	wire         isWrite     = cmdField == PCPL_CMD_WRITE;
	wire         allowChange = writeProt_b;
	wire         doRestore   = execute && isRestore;
	wire         doStore     = execute && isStore && allowChange;
	wire         doWrite     = execute && isWrite && allowChange;
	wire         nvOutHit    = isStore && addrField == PCPL_ADDR_NVOUT;
	wire         doneEvent   = (execute && isRead) || presetRise;
	wire [1:0]   chanSel     = addrField[1:0];
	wire         chanHit     = addrField[3:2] == 2'b00;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			toggle_reg    <= 1'b0;
			preset_reg    <= 1'b1;
			wordPend_reg  <= 1'b0;
			word_reg      <= '0;
			wordValid_reg <= 1'b0;
		end else if (ce) begin
			toggle_reg    <= toggleSync;
			preset_reg    <= presetSync;
			// Words arriving while a store runs are dropped
			wordPend_reg  <= newWord && idle;
			// Word bits settle one cycle behind the toggle
			wordValid_reg <= wordPend_reg;
			if (wordPend_reg) begin
				word_reg <= wordSync;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < PCPL_CHANNELS; ch++) begin : g_chan
			// Channel addresses 0x0..0x3 map straight onto index
			wire hit = chanHit && chanSel == 2'(ch);
			// Output-bit stores leave the wiper store alone
			wire storeHit = state_reg == PCPL_STORING && count_reg == 32'h1
				&& storeWiper_reg && storeCh_reg == 2'(ch);
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					wiper_reg[ch]   <= PCPL_MIDSCALE;
					nvStore_reg[ch] <= PCPL_MIDSCALE;
				end else if (ce) begin
					if (presetLow)
						wiper_reg[ch] <= PCPL_MIDSCALE;
					else if (presetRise)
						wiper_reg[ch] <= nvStore_reg[ch];
					else if (doRestore && (cmdField == PCPL_CMD_RESET_NV || hit))
						wiper_reg[ch] <= nvStore_reg[ch];
					else if (doWrite && hit)
						wiper_reg[ch] <= dataField;
					if (storeHit)
						nvStore_reg[ch] <= wiper_reg[ch];
				end
			end
			assign wiperFlat[ch*6 +: 6] = wiper_reg[ch];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nvOne_reg <= PCPL_NVOUT_RESET;
			nvTwo_reg <= PCPL_NVOUT_RESET;
		end else if (ce) begin
			if (doStore && nvOutHit) begin
				nvOne_reg <= word_reg[PCPL_OUT_ONE_BIT];
				nvTwo_reg <= word_reg[PCPL_OUT_TWO_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg    <= PCPL_IDLE;
			count_reg    <= '0;
			storeCh_reg  <= '0;
			storeWiper_reg <= 1'b0;
		end else if (ce) begin
			case (state_reg)
				PCPL_IDLE: begin
					if (doStore) begin
						state_reg    <= PCPL_STORING;
						count_reg    <= 32'(STORE_CYCLES);
						storeCh_reg  <= chanSel;
						storeWiper_reg <= chanHit;
					end else if (doneEvent) begin
						state_reg <= PCPL_READY;
						count_reg <= 32'(READY_CYCLES);
					end
				end
				PCPL_STORING: begin
					if (count_reg == 32'h1) begin
						state_reg <= PCPL_READY;
						count_reg <= 32'(READY_CYCLES);
					end else begin
						count_reg <= count_reg - 32'h1;
					end
				end
				PCPL_READY: begin
					if (count_reg == 32'h1)
						state_reg <= PCPL_IDLE;
					else
						count_reg <= count_reg - 32'h1;
				end
				default: state_reg <= PCPL_IDLE;
			endcase
		end
	end

	// Ready high while idle, pulses low while busy and during the done mark
	logic readyLevel;
	assign readyLevel = state_reg == PCPL_IDLE;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readyOut           <= 1'b0;
			readyOe_b          <= 1'b1;
			nv_digital_out_one <= PCPL_NVOUT_RESET;
			nv_digital_out_two <= PCPL_NVOUT_RESET;
			storeBusy          <= 1'b0;
		end else if (ce) begin
			readyOut           <= 1'b0;
			readyOe_b          <= readyLevel;
			nv_digital_out_one <= nvOne_reg;
			nv_digital_out_two <= nvTwo_reg;
			storeBusy          <= state_reg == PCPL_STORING;
		end
	end

	property p_store_blocked;
		@(posedge clk) disable iff (!rst_b)
		(ce && execute && isStore && !writeProt_b) |=> state_reg != PCPL_STORING;
	endproperty
	a_store_blocked: assert property (p_store_blocked) else $error("store ran under write protect");

	property p_write_blocked;
		@(posedge clk) disable iff (!rst_b)
		(ce && execute && isWrite && !writeProt_b && presetSync && !presetRise)
			|=> $stable(wiperFlat);
	endproperty
	a_write_blocked: assert property (p_write_blocked) else $error("wiper changed under write protect");

	property p_preset_reload;
		@(posedge clk) disable iff (!rst_b)
		(ce && presetRise) |=> wiper_reg[0] == $past(nvStore_reg[0]);
	endproperty
	a_preset_reload: assert property (p_preset_reload) else $error("preset did not reload wiper");

	property p_preset_low_mid;
		@(posedge clk) disable iff (!rst_b)
		(ce && presetLow) |=> wiper_reg[2] == PCPL_MIDSCALE;
	endproperty
	a_preset_low_mid: assert property (p_preset_low_mid) else $error("wiper not midscale while preset low");

	property p_ready_done;
		@(posedge clk) disable iff (!rst_b)
		(ce && state_reg == PCPL_IDLE && doneEvent && !doStore) |=> ##1 !readyOe_b;
	endproperty
	a_ready_done: assert property (p_ready_done) else $error("ready did not mark completion");

	property p_write_ch4;
		@(posedge clk) disable iff (!rst_b)
		(ce && doWrite && addrField == PCPL_ADDR_CH4 && presetSync && !presetRise)
			|=> wiper_reg[3] == $past(dataField);
	endproperty
	a_write_ch4: assert property (p_write_ch4) else $error("channel four not written");

	property p_write_ch1;
		@(posedge clk) disable iff (!rst_b)
		(ce && doWrite && addrField == PCPL_ADDR_CH1 && presetSync && !presetRise)
			|=> wiper_reg[0] == $past(dataField) && $stable(wiper_reg[1]);
	endproperty
	a_write_ch1: assert property (p_write_ch1) else $error("channel one write wrong");

	property p_nvout;
		@(posedge clk) disable iff (!rst_b)
		(ce && doStore && nvOutHit) |=> ##1 nv_digital_out_one == $past(word_reg[0], 2)
			&& nv_digital_out_two == $past(word_reg[1], 2);
	endproperty
	a_nvout: assert property (p_nvout) else $error("digital outputs not updated");

	property p_execute_after_word;
		@(posedge clk) disable iff (!rst_b)
		$rose(wordValid_reg) |-> $past(wordPend_reg);
	endproperty
	a_execute_after_word: assert property (p_execute_after_word) else $error("word ran without select rise");

	c_store: cover property (@(posedge clk) disable iff (!rst_b) state_reg == PCPL_STORING);
	c_preset: cover property (@(posedge clk) disable iff (!rst_b) presetRise);
	c_write: cover property (@(posedge clk) disable iff (!rst_b) doWrite);
	property p_nvout_protect;
		@(posedge clk) disable iff (!rst_b)
		(ce && execute && nvOutHit && !writeProt_b) |=> $stable(nvOne_reg) && $stable(nvTwo_reg);
	endproperty
	a_nvout_protect: assert property (p_nvout_protect) else $error("output bit changed under write protect");

	property p_restore_all;
		@(posedge clk) disable iff (!rst_b)
		(ce && doRestore && cmdField == PCPL_CMD_RESET_NV && presetSync && !presetRise)
			|=> wiper_reg[3] == $past(nvStore_reg[3]) && wiper_reg[1] == $past(nvStore_reg[1]);
	endproperty
	a_restore_all: assert property (p_restore_all) else $error("restore all missed a channel");

	c_protect: cover property (@(posedge clk) disable iff (!rst_b) execute && !writeProt_b);
	c_ready: cover property (@(posedge clk) disable iff (!rst_b) !readyOe_b);
endmodule // pcpl_pot_control

// ---- core/pcpl_pkg.sv ----
package pcpl_pkg;
	localparam int          PCPL_WORD_BITS    = 16;
	localparam int          PCPL_WIPER_BITS   = 6;
	localparam int          PCPL_CHANNELS     = 4;
	localparam int          PCPL_CMD_MSB      = 15;
	localparam int          PCPL_CMD_LSB      = 12;
	localparam int          PCPL_ADDR_MSB     = 11;
	localparam int          PCPL_ADDR_LSB     = 8;
	localparam int          PCPL_OUT_ONE_BIT  = 0;
	localparam int          PCPL_OUT_TWO_BIT  = 1;
	localparam logic [3:0]  PCPL_ADDR_CH1     = 4'h0;
	localparam logic [3:0]  PCPL_ADDR_CH2     = 4'h1;
	localparam logic [3:0]  PCPL_ADDR_CH3     = 4'h2;
	localparam logic [3:0]  PCPL_ADDR_CH4     = 4'h3;
	localparam logic [3:0]  PCPL_ADDR_NVOUT   = 4'h4;
	localparam logic [3:0]  PCPL_CMD_NOP      = 4'h0;
	localparam logic [3:0]  PCPL_CMD_RESTORE  = 4'h1;
	localparam logic [3:0]  PCPL_CMD_STORE    = 4'h2;
	localparam logic [3:0]  PCPL_CMD_STORE_U  = 4'h3;
	localparam logic [3:0]  PCPL_CMD_RESET_NV = 4'h8;
	localparam logic [3:0]  PCPL_CMD_READ_NV  = 4'h9;
	localparam logic [3:0]  PCPL_CMD_READ_W   = 4'ha;
	localparam logic [3:0]  PCPL_CMD_WRITE    = 4'hb;
	localparam logic [5:0]  PCPL_MIDSCALE     = 6'h20;
	localparam logic        PCPL_NVOUT_RESET  = 1'b1;
	localparam int          PCPL_CLK_MHZ      = 250;
	localparam int          PCPL_STORE_US     = 25000;
	localparam int          PCPL_STORE_CYC    = PCPL_STORE_US * PCPL_CLK_MHZ;
	localparam int          PCPL_READY_NS     = 8;
	localparam int          PCPL_READY_CYC    = (PCPL_READY_NS * PCPL_CLK_MHZ + 999) / 1000;
endpackage

// ---- core/pcpl_sync.sv ----
`timescale 1ns/1ps
module pcpl_sync
	import pcpl_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	initial begin
		if (WIDTH < 1) $error("pcpl_sync: WIDTH must be positive");
	end
	logic [WIDTH-1:0] stage1_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_reg <= '1;
			syncOut    <= '1;
		end else if (ce) begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule // pcpl_sync

// ---- core/pcpl_shift.sv ----
`timescale 1ns/1ps
// Link-clock side: shifts the word while chip select is low, toggles on rise.
module pcpl_shift
	import pcpl_pkg::*;
#(
	parameter int WORD_BITS = PCPL_WORD_BITS
) (
	input  wire logic                 linkClk,
	input  wire logic                 rst_b,
	input  wire logic                 chipSel_b,
	input  wire logic                 serialIn,
	output logic      [WORD_BITS-1:0] wordOut,
	output logic                      wordToggle
);
	initial begin
		if (WORD_BITS != PCPL_WORD_BITS) $error("pcpl_shift: word width fixed at 16");
	end
	logic [WORD_BITS-1:0] shift_reg;
	// MSB first, one bit per rising edge
	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			shift_reg <= '0;
		end else if (!chipSel_b) begin
			shift_reg <= {shift_reg[WORD_BITS-2:0], serialIn};
		end
	end
	// Capture on chip-select rise, clocked by the rising select itself
	always_ff @(posedge chipSel_b or negedge rst_b) begin
		if (!rst_b) begin
			wordOut    <= '0;
			wordToggle <= 1'b0;
		end else begin
			wordOut    <= shift_reg;
			wordToggle <= ~wordToggle;
		end
	end
endmodule // pcpl_shift

// ---- verification/pcpl_host_model.sv ----
`timescale 1ns/1ps
// Host side of the serial link; link clock runs only inside frames
module pcpl_host_model (
	output logic linkClk,
	output logic chipSel_b,
	output logic serialIn
);
	initial begin
		linkClk = 1'b0;
		chipSel_b = 1'b1;
		serialIn = 1'b0;
	end

	task automatic sendWord(input logic [15:0] w);
		#5 chipSel_b = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serialIn = w[i];
			#16 linkClk = 1'b1;
			#16 linkClk = 1'b0;
		end
		#16 chipSel_b = 1'b1;
		serialIn = ~serialIn;
	endtask
endmodule // pcpl_host_model

// ---- verification/test_pcpl_pot_control.sv ----
`timescale 1ns/1ps
module test_pcpl_pot_control;
	import pcpl_pkg::*;
	logic        clk, rst_b, ce, writeProtect_b, preset_strobe_n;
	logic        linkClk, chipSel_b, serialIn;
	logic        readyOut, readyOe_b, nvOne, nvTwo, storeBusy;
	logic [23:0] wiperFlat;
	wire         readyPin = readyOe_b ? 1'b1 : readyOut;
	wire  [29:0] obs      = {nvTwo, nvOne, wiperFlat};
	logic [29:0] last;
	logic [29:0] held;
	logic [29:0] notes[$];
	logic [5:0]  wip[4], stored[4];
	logic [1:0]  nv;
	int          mismatches, n_checks, cycles;
	integer      seed, rnd;

	pcpl_host_model pcpl_host_model_inst (.linkClk(linkClk), .chipSel_b(chipSel_b), .serialIn(serialIn));
	pcpl_pot_control #(.STORE_CYCLES(20), .READY_CYCLES(2)) pcpl_pot_control_inst (
		.clk(clk), .rst_b(rst_b), .ce(ce), .linkClk(linkClk), .chipSel_b(chipSel_b),
		.serialIn(serialIn), .writeProtect_b(writeProtect_b), .preset_strobe_n(preset_strobe_n),
		.readyOut(readyOut), .readyOe_b(readyOe_b), .nv_digital_out_one(nvOne),
		.nv_digital_out_two(nvTwo), .wiperFlat(wiperFlat), .storeBusy(storeBusy));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [29:0] seen, input logic [29:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [29:0] expState();
		return {nv[1], nv[0], wip[3], wip[2], wip[1], wip[0]};
	endfunction

	task automatic note();
		notes.push_back(expState());
	endtask

	task automatic waitReady(input bit busy);
		int n;
		n = 0;
		while (readyPin !== 1'b0 && n < 80) begin
			@(posedge clk);
			n++;
		end
		check({29'h0, readyPin}, 30'h0);
		check({29'h0, storeBusy}, {29'h0, busy});
		while (readyPin !== 1'b1 && n < 120) begin
			@(posedge clk);
			n++;
		end
		check({29'h0, readyPin}, 30'h1);
	endtask

	task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [5:0] d, input bit rdy);
		@(posedge clk);
		pcpl_host_model_inst.sendWord({c, a, 2'b00, d});
		if (rdy) begin
			waitReady(c == PCPL_CMD_STORE || c == PCPL_CMD_STORE_U);
		end
		repeat (12) @(posedge clk);
	endtask

	// Watches wiper and output state; every change must match the oldest note
	always @(posedge clk) begin
		if (rst_b && obs !== last) begin
			if (notes.size() == 0) begin
				check(obs, last);
			end else begin
				check(obs, notes.pop_front());
			end
		end
		last <= obs;
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		seed = 32'h8241fe8c;
		cycles = 0;
		mismatches = 0;
		n_checks = 0;
		rst_b = 1'b0;
		ce = 1'b1;
		writeProtect_b = 1'b1;
		preset_strobe_n = 1'b1;
		nv = 2'b11;
		for (int i = 0; i < 4; i++) begin
			wip[i] = PCPL_MIDSCALE;
			stored[i] = PCPL_MIDSCALE;
		end
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		check(obs, expState());
		check({29'h0, readyPin}, 30'h1);
		for (int a = 0; a < 4; a++) begin
			rnd = $random(seed);
			wip[a] = {1'b0, rnd[4:0]};
			note();
			cmd(PCPL_CMD_WRITE, a[3:0], wip[a], 1'b0);
		end
		stored[0] = wip[0];
		cmd(PCPL_CMD_STORE, PCPL_ADDR_CH1, 6'h00, 1'b1);
		nv = 2'b01;
		note();
		cmd(PCPL_CMD_STORE, PCPL_ADDR_NVOUT, 6'h01, 1'b1);
		nv = 2'b10;
		note();
		cmd(PCPL_CMD_STORE_U, PCPL_ADDR_NVOUT, 6'h02, 1'b1);
		wip[0] = wip[0] ^ 6'h01;
		note();
		cmd(PCPL_CMD_WRITE, PCPL_ADDR_CH1, wip[0], 1'b0);
		wip[0] = stored[0];
		note();
		cmd(PCPL_CMD_RESTORE, PCPL_ADDR_CH1, 6'h00, 1'b0);
		for (int i = 0; i < 4; i++) wip[i] = PCPL_MIDSCALE;
		note();
		preset_strobe_n <= 1'b0;
		repeat (10) @(posedge clk);
		for (int i = 0; i < 4; i++) wip[i] = stored[i];
		note();
		preset_strobe_n <= 1'b1;
		waitReady(1'b0);
		cmd(PCPL_CMD_NOP, 4'h0, 6'h00, 1'b0);
		rnd = $random(seed);
		wip[1] = {1'b0, rnd[4:0]};
		note();
		cmd(PCPL_CMD_WRITE, PCPL_ADDR_CH2, wip[1], 1'b0);
		writeProtect_b <= 1'b0;
		repeat (4) @(posedge clk);
		cmd(PCPL_CMD_WRITE, PCPL_ADDR_CH2, ~wip[1], 1'b0);
		cmd(PCPL_CMD_STORE, PCPL_ADDR_NVOUT, 6'h01, 1'b0);
		wip[1] = stored[1];
		note();
		cmd(PCPL_CMD_RESET_NV, 4'h0, 6'h00, 1'b0);
		cmd(PCPL_CMD_NOP, 4'h0, 6'h00, 1'b0);
		writeProtect_b <= 1'b1;
		cmd(PCPL_CMD_READ_NV, PCPL_ADDR_CH1, 6'h00, 1'b1);
		cmd(PCPL_CMD_READ_W, PCPL_ADDR_CH4, 6'h00, 1'b1);
		// Clock enable low holds a finished word until it returns
		held = expState();
		rnd = $random(seed);
		wip[2] = {1'b0, rnd[4:0]};
		note();
		ce <= 1'b0;
		cmd(PCPL_CMD_WRITE, PCPL_ADDR_CH3, wip[2], 1'b0);
		check(obs, held);
		ce <= 1'b1;
		repeat (12) @(posedge clk);
		check(30'(notes.size()), 30'h0);
		close_out();
	end
endmodule // test_pcpl_pot_control
